// ### rtl/shub_pkg.sv
`default_nettype none
package shub_pkg;
  // Command family codes
  localparam logic [7:0] FAM_LOAD = 8'h14;
  localparam logic [7:0] FAM_WR   = 8'h40;
  localparam logic [7:0] FAM_RD   = 8'h41;
  localparam logic [7:0] FAM_ATTR = 8'h42;
  localparam logic [7:0] FAM_DUMP = 8'h43;
  // Sensor index codes
  localparam logic [7:0] IDX_AFE_FIRST = 8'h00;
  localparam logic [7:0] IDX_AFE_LAST  = 8'h03;
  localparam logic [7:0] IDX_ACCEL     = 8'h04;
  localparam int         NUM_SENS      = 5;
  // One external accelerometer sample: three 16-bit axes
  localparam logic [7:0] SAMPLE_BYTES  = 8'h06;
  localparam int         FIFO_W        = 8;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         REM_W         = 11;
  // Per-sensor defaults, one byte per index (one bit in PRESENT_DEF), index 0 in the lowest byte or bit
  localparam logic [4:0]  PRESENT_DEF  = 5'h1f;
  localparam logic [39:0] WBYTES_DEF   = 40'h01_0101_0101;
  localparam logic [39:0] NREGS_DEF    = 40'h40_4040_4040;

  typedef struct packed {
    logic       we;
    logic [2:0] idx;
    logic [7:0] addr;
    logic [7:0] wdata;
  } shub_sacc_s;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_INDEX = 9'h002,
    ST_ADDR  = 9'h004,
    ST_VALUE = 9'h008,
    ST_COUNT = 9'h010,
    ST_LOAD  = 9'h020,
    ST_ACC   = 9'h040,
    ST_SEND  = 9'h080,
    ST_DRAIN = 9'h100
  } shub_state_e;
endpackage
`default_nettype wire

// ### rtl/shub_fifo.sv
`default_nettype none
module shub_fifo
  import shub_pkg::*;
#(
  parameter int W     = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_ff [DEPTH];
  logic [W-1:0] nxt_mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = in_data;
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
    case ({push, pop})
      2'b10:   nxt_cnt = cnt_ff + 1'b1;
      2'b01:   nxt_cnt = cnt_ff - 1'b1;
      default: nxt_cnt = cnt_ff;
    endcase
  end

  always_ff @(posedge mclk) begin
    mem_ff <= nxt_mem;
    if (reset) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // shub_fifo
`default_nettype wire

// ### rtl/shub_attr.sv
`default_nettype none
module shub_attr
  import shub_pkg::*;
#(
  parameter logic [4:0]  PRESENT = PRESENT_DEF,
  parameter logic [39:0] WBYTES  = WBYTES_DEF,
  parameter logic [39:0] NREGS   = NREGS_DEF
) (
  input  wire logic [7:0] idx,
  output logic            present,
  output logic [7:0]      word_bytes,
  output logic [7:0]      nregs
);
  logic [7:0] wb_a [NUM_SENS];
  logic [7:0] nr_a [NUM_SENS];

  for (genvar i = 0; i < NUM_SENS; i++) begin : g_ent
    assign wb_a[i] = WBYTES[8*i +: 8];
    assign nr_a[i] = NREGS[8*i +: 8];
  end

  always_comb begin
    present    = 1'b0;
    word_bytes = 8'h00;
    nregs      = 8'h00;
    if (idx >= IDX_AFE_FIRST && idx <= IDX_ACCEL) begin
      present    = PRESENT[idx[2:0]];
      word_bytes = wb_a[idx[2:0]];
      nregs      = nr_a[idx[2:0]];
    end
  end
endmodule // shub_attr
`default_nettype wire

// ### rtl/shub_cmd.sv
// Summary of operation
// - Family 0x14 loads samples into input FIFO.
// - Family 0x40 writes one sensor register.
// - Family 0x41 returns one sensor register value.
// - Index 0x00-0x03 front ends, 0x04 accelerometer.
// - Family 0x42 returns word bytes, register count.
// - Family 0x43 dumps address/value pairs ascending.
`default_nettype none
module shub_cmd
  import shub_pkg::*;
#(
  parameter logic [4:0]  PRESENT = PRESENT_DEF,
  parameter logic [39:0] WBYTES  = WBYTES_DEF,
  parameter logic [39:0] NREGS   = NREGS_DEF,
  parameter int          DEPTH   = FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             sens_req,
  output shub_sacc_s       sens_cmd,
  input  wire logic        sens_ack,
  input  wire logic [7:0]  sens_rdata,
  output logic             acc_valid,
  output logic [7:0]       acc_data,
  input  wire logic        acc_ready,
  output logic             cmd_err
);
  shub_state_e      state_ff, nxt_state;
  logic [7:0]       fam_ff, nxt_fam;
  logic [7:0]       addr_ff, nxt_addr;
  logic [7:0]       val_ff, nxt_val;
  logic [7:0]       hold_ff, nxt_hold;
  logic [REM_W-1:0] rem_ff, nxt_rem;
  logic             hold_v_ff, nxt_hold_v;
  logic             last_ff, nxt_last;
  logic             step_ff, nxt_step;
  logic             rx_ready_ff, nxt_rx_ready;
  logic             tx_valid_ff, nxt_tx_valid;
  logic [7:0]       tx_data_ff, nxt_tx_data;
  logic             sreq_ff, nxt_sreq;
  shub_sacc_s       scmd_ff, nxt_scmd;
  logic             err_ff, nxt_err;
  logic             rx_fire, fifo_in_ready, fifo_push;
  logic [7:0]       attr_idx, a_wbytes, a_nregs;
  logic             a_present, idx_ok, fam_known;

  assign rx_fire   = rx_valid && rx_ready_ff;
  assign fifo_push = hold_v_ff && fifo_in_ready;
  assign attr_idx  = (state_ff == ST_INDEX) ? rx_data : {5'h00, scmd_ff.idx};
  assign idx_ok    = (rx_data <= IDX_ACCEL) && a_present;
  assign fam_known = (rx_data == FAM_LOAD) || (rx_data == FAM_WR) || (rx_data == FAM_RD)
                  || (rx_data == FAM_ATTR) || (rx_data == FAM_DUMP);

  shub_attr #(
    .PRESENT (PRESENT),
    .WBYTES  (WBYTES),
    .NREGS   (NREGS)
  ) u_attr (
    .idx        (attr_idx),
    .present    (a_present),
    .word_bytes (a_wbytes),
    .nregs      (a_nregs)
  );

  shub_fifo #(
    .W     (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (hold_v_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_ff),
    .out_valid (acc_valid),
    .out_ready (acc_ready),
    .out_data  (acc_data)
  );

  always_comb begin
    nxt_state    = state_ff;
    nxt_fam      = fam_ff;
    nxt_addr     = addr_ff;
    nxt_val      = val_ff;
    nxt_hold     = hold_ff;
    nxt_hold_v   = hold_v_ff;
    nxt_rem      = rem_ff;
    nxt_last     = last_ff;
    nxt_step     = step_ff;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_data  = tx_data_ff;
    nxt_sreq     = sreq_ff;
    nxt_scmd     = scmd_ff;
    nxt_err      = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (rx_fire) begin
          nxt_fam = rx_data;
          if (!fam_known || rx_last) begin
            nxt_err   = 1'b1;
            nxt_state = rx_last ? ST_IDLE : ST_DRAIN;
          end else begin
            nxt_state = ST_INDEX;
          end
        end
      end
      ST_INDEX: begin
        if (rx_fire) begin
          if (fam_ff == FAM_LOAD) begin
            nxt_err   = rx_last;
            nxt_state = rx_last ? ST_IDLE : ST_COUNT;
          end else if (!idx_ok) begin
            nxt_err   = 1'b1;
            nxt_state = rx_last ? ST_IDLE : ST_DRAIN;
          end else begin
            nxt_scmd.idx = rx_data[2:0];
            if (fam_ff == FAM_WR || fam_ff == FAM_RD) begin
              nxt_err   = rx_last;
              nxt_state = rx_last ? ST_IDLE : ST_ADDR;
            end else if (!rx_last) begin
              nxt_err   = 1'b1;
              nxt_state = ST_DRAIN;
            end else if (fam_ff == FAM_ATTR) begin
              nxt_tx_data  = a_wbytes;
              nxt_tx_valid = 1'b1;
              nxt_step     = 1'b0;
              nxt_state    = ST_SEND;
            end else if (a_nregs == 8'h00) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_addr      = 8'h00;
              nxt_scmd.we   = 1'b0;
              nxt_scmd.addr = 8'h00;
              nxt_sreq      = 1'b1;
              nxt_state     = ST_ACC;
            end
          end
        end
      end
      ST_ADDR: begin
        if (rx_fire) begin
          nxt_addr      = rx_data;
          nxt_scmd.addr = rx_data;
          if (rx_data >= a_nregs) begin
            nxt_err   = 1'b1;
            nxt_state = rx_last ? ST_IDLE : ST_DRAIN;
          end else if (fam_ff == FAM_WR) begin
            nxt_err   = rx_last;
            nxt_state = rx_last ? ST_IDLE : ST_VALUE;
          end else if (!rx_last) begin
            nxt_err   = 1'b1;
            nxt_state = ST_DRAIN;
          end else begin
            nxt_scmd.we = 1'b0;
            nxt_sreq    = 1'b1;
            nxt_state   = ST_ACC;
          end
        end
      end
      ST_VALUE: begin
        if (rx_fire) begin
          if (!rx_last) begin
            nxt_err   = 1'b1;
            nxt_state = ST_DRAIN;
          end else begin
            nxt_scmd.we    = 1'b1;
            nxt_scmd.wdata = rx_data;
            nxt_sreq       = 1'b1;
            nxt_state      = ST_ACC;
          end
        end
      end
      ST_ACC: begin
        if (sens_ack && sreq_ff) begin
          nxt_sreq = 1'b0;
          if (scmd_ff.we) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_val      = sens_rdata;
            nxt_tx_valid = 1'b1;
            nxt_state    = ST_SEND;
            nxt_step     = (fam_ff != FAM_DUMP);
            nxt_tx_data  = (fam_ff == FAM_DUMP) ? addr_ff : sens_rdata;
          end
        end
      end
      ST_SEND: begin
        if (tx_ready) begin
          if (!step_ff) begin
            nxt_step    = 1'b1;
            nxt_tx_data = (fam_ff == FAM_ATTR) ? a_nregs : val_ff;
          end else if (fam_ff == FAM_DUMP && (addr_ff + 8'h01) < a_nregs) begin
            nxt_tx_valid  = 1'b0;
            nxt_addr      = addr_ff + 8'h01;
            nxt_scmd.addr = addr_ff + 8'h01;
            nxt_sreq      = 1'b1;
            nxt_state     = ST_ACC;
          end else begin
            nxt_tx_valid = 1'b0;
            nxt_state    = ST_IDLE;
          end
        end
      end
      ST_COUNT: begin
        if (rx_fire) begin
          nxt_rem = REM_W'(rx_data) * REM_W'(SAMPLE_BYTES);
          if (rx_last) begin
            nxt_err   = (rx_data != 8'h00);
            nxt_state = ST_IDLE;
          end else begin
            nxt_err   = (rx_data == 8'h00);
            nxt_state = (rx_data == 8'h00) ? ST_DRAIN : ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        if (rx_fire) begin
          nxt_hold   = rx_data;
          nxt_hold_v = 1'b1;
          nxt_last   = rx_last;
          nxt_rem    = rx_last ? '0 : rem_ff - 1'b1;
          nxt_err    = rx_last && (rem_ff != REM_W'(1));
        end else if (fifo_push) begin
          nxt_hold_v = 1'b0;
          if (rem_ff == '0) begin
            nxt_err   = !last_ff;
            nxt_state = last_ff ? ST_IDLE : ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (rx_fire && rx_last) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Ready is registered, so it is lowered while a byte waits for the FIFO
    nxt_rx_ready = (nxt_state == ST_IDLE) || (nxt_state == ST_INDEX)
                || (nxt_state == ST_ADDR) || (nxt_state == ST_VALUE)
                || (nxt_state == ST_COUNT) || (nxt_state == ST_DRAIN)
                || ((nxt_state == ST_LOAD) && !nxt_hold_v);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff    <= ST_IDLE;
      fam_ff      <= 8'h00;
      addr_ff     <= 8'h00;
      val_ff      <= 8'h00;
      hold_ff     <= 8'h00;
      hold_v_ff   <= 1'b0;
      rem_ff      <= '0;
      last_ff     <= 1'b0;
      step_ff     <= 1'b0;
      rx_ready_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
      sreq_ff     <= 1'b0;
      scmd_ff     <= '0;
      err_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      fam_ff      <= nxt_fam;
      addr_ff     <= nxt_addr;
      val_ff      <= nxt_val;
      hold_ff     <= nxt_hold;
      hold_v_ff   <= nxt_hold_v;
      rem_ff      <= nxt_rem;
      last_ff     <= nxt_last;
      step_ff     <= nxt_step;
      rx_ready_ff <= nxt_rx_ready;
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff  <= nxt_tx_data;
      sreq_ff     <= nxt_sreq;
      scmd_ff     <= nxt_scmd;
      err_ff      <= nxt_err;
    end
  end

  assign rx_ready = rx_ready_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data  = tx_data_ff;
  assign sens_req = sreq_ff;
  assign sens_cmd = scmd_ff;
  assign cmd_err  = err_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_load_only;
    fifo_push |-> (state_ff == ST_LOAD);
  endproperty
  a_load_only: assert property (p_load_only) else $error("FIFO push outside load");

  property p_load_cnt;
    (state_ff == ST_COUNT) && rx_fire && !rx_last |=> rem_ff == REM_W'($past(rx_data)) * 11'h006;
  endproperty
  a_load_cnt: assert property (p_load_cnt) else $error("Load byte count wrong");

  property p_wr_fwd;
    (state_ff == ST_VALUE) && rx_fire && rx_last
      |=> sens_req && sens_cmd.we && sens_cmd.wdata == $past(rx_data);
  endproperty
  a_wr_fwd: assert property (p_wr_fwd) else $error("Write not forwarded");

  property p_rd_resp;
    (state_ff == ST_ACC) && sens_ack && sreq_ff && !scmd_ff.we && fam_ff == FAM_RD
      |=> tx_valid && tx_data == $past(sens_rdata) && !sens_req;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("Read value not returned");

  property p_idx;
    sens_req |-> sens_cmd.idx <= IDX_ACCEL[2:0];
  endproperty
  a_idx: assert property (p_idx) else $error("Sensor index out of range");

  property p_attr;
    (state_ff == ST_SEND) && fam_ff == FAM_ATTR && !step_ff && tx_ready
      |=> tx_valid && tx_data == a_nregs;
  endproperty
  a_attr: assert property (p_attr) else $error("Attribute count not sent");

  property p_dump_next;
    (state_ff == ST_SEND) && fam_ff == FAM_DUMP && step_ff && tx_ready && nxt_state == ST_ACC
      |=> sens_req && !sens_cmd.we && sens_cmd.addr == $past(addr_ff) + 8'h01;
  endproperty
  a_dump_next: assert property (p_dump_next) else $error("Dump address skipped");

  property p_reject;
    (state_ff == ST_INDEX) && rx_fire && fam_ff != FAM_LOAD && !idx_ok
      |=> cmd_err && !sens_req && !tx_valid;
  endproperty
  a_reject: assert property (p_reject) else $error("Bad index not rejected");

  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("Response byte dropped");

  c_write: cover property ((state_ff == ST_ACC) && sens_ack && scmd_ff.we);
  c_dump2: cover property ((state_ff == ST_ACC) && fam_ff == FAM_DUMP && scmd_ff.addr == 8'h01);
  c_attr:  cover property ((state_ff == ST_SEND) && fam_ff == FAM_ATTR && step_ff && tx_ready);
  c_full:  cover property (hold_v_ff && !fifo_in_ready);
endmodule // shub_cmd
`default_nettype wire

// ### sim/shub_sens_model.sv
`default_nettype none
module shub_sens_model
  import shub_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       sens_req,
  input  wire shub_sacc_s sens_cmd,
  output logic            sens_ack,
  output logic [7:0]      sens_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [NUM_SENS][256];
  int         wait_cnt;
  int         n_acc;

  initial begin
    for (int i = 0; i < NUM_SENS; i++) begin
      for (int a = 0; a < 256; a++) begin
        mem[i][a] = 8'(i * 32 + a) ^ 8'h5a;
      end
    end
    sens_ack = 1'b0;
    sens_rdata = 8'h00;
    wait_cnt = 0;
    n_acc = 0;
  end

  // Read data toggles outside the ack cycle so a stale value is never mistaken for a good one
  always @(posedge mclk) begin
    sens_ack <= 1'b0;
    sens_rdata <= ~sens_rdata;
    if (reset) begin
      wait_cnt <= 0;
    end else if (sens_req && !sens_ack) begin
      if (wait_cnt < (slow ? 3 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        sens_ack <= 1'b1;
        n_acc <= n_acc + 1;
        if (sens_cmd.we) begin
          mem[sens_cmd.idx][sens_cmd.addr] <= sens_cmd.wdata;
        end else begin
          sens_rdata <= mem[sens_cmd.idx][sens_cmd.addr];
        end
      end
    end
  end
endmodule // shub_sens_model
`default_nettype wire

// ### sim/shub_cmd_tb.sv
`default_nettype none
module shub_cmd_tb
  import shub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [39:0] WB = 40'h02_0101_0104;
  localparam logic [39:0] NR = 40'h08_1020_3040;
  localparam logic [4:0]  PR = 5'h1d;
  logic       mclk, reset, rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
  logic       sens_req, sens_ack, acc_valid, acc_ready, cmd_err, slow;
  logic [7:0] rx_data, tx_data, sens_rdata, acc_data;
  shub_sacc_s sens_cmd;
  int         fails, n_compared, errs, txs;
  logic [7:0] acc_q [$];

  shub_cmd #(.PRESENT(PR), .WBYTES(WB), .NREGS(NR), .DEPTH(8)) DUT (
    .mclk(mclk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .sens_req(sens_req), .sens_cmd(sens_cmd), .sens_ack(sens_ack),
    .sens_rdata(sens_rdata), .acc_valid(acc_valid), .acc_data(acc_data),
    .acc_ready(acc_ready), .cmd_err(cmd_err));

  shub_sens_model u_sens (
    .mclk(mclk), .reset(reset), .slow(slow), .sens_req(sens_req),
    .sens_cmd(sens_cmd), .sens_ack(sens_ack), .sens_rdata(sens_rdata));

  task automatic tally_and_finish();
    $display("Counts: compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Byte is held until an edge sees rx_ready high
  task automatic put(input logic [7:0] b, input logic l);
    int n;
    n = 0;
    rx_valid = 1'b1;
    rx_data = b;
    rx_last = l;
    while (rx_ready !== 1'b1 && n < 500) begin
      step(1);
      n++;
    end
    step(1);
  endtask

  // Valid stays up so frames can follow back to back; idle() releases it
  task automatic frame(input logic [7:0] q [$]);
    foreach (q[i]) put(q[i], i == q.size() - 1);
  endtask

  task automatic idle();
    rx_valid = 1'b0;
    rx_last = 1'b0;
  endtask

  task automatic get(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 500) begin
      step(1);
      n++;
    end
    chk(what, exp, tx_data);
    step(1);
  endtask

  always @(negedge mclk) begin
    if (cmd_err === 1'b1) errs++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txs++;
    if (acc_valid === 1'b1 && acc_ready === 1'b1) acc_q.push_back(acc_data);
  end

  task automatic t_wr_rd();
    logic [7:0] i;
    int         t0;
    t0 = txs;
    for (int k = 0; k < 5; k++) begin
      i = 8'(k);
      slow = i[0];
      if (k != 1) begin
        frame({FAM_WR, i, i + 8'h01, 8'hc0 | i});
        frame({FAM_RD, i, i + 8'h01});
        idle();
        get("read value", 8'hc0 | i);
        chk("sensor reg", 8'hc0 | i, u_sens.mem[k][k + 1]);
      end
    end
    chk("response count", 8'h04, 8'(txs - t0));
  endtask

  task automatic t_attr();
    int e0;
    for (int k = 0; k < 5; k++) begin
      e0 = errs;
      frame({FAM_ATTR, 8'(k)});
      idle();
      if (k == 1) begin
        step(4);
        chk("absent sensor err", 8'h01, 8'(errs - e0));
      end else begin
        get("word bytes", WB[k*8 +: 8]);
        get("reg count", NR[k*8 +: 8]);
      end
    end
  endtask

  task automatic t_dump();
    tx_ready = 1'b0;
    frame({FAM_DUMP, IDX_ACCEL});
    idle();
    step(8);
    chk("stalled valid", 8'h01, {7'h00, tx_valid});
    chk("stalled addr", 8'h00, tx_data);
    tx_ready = 1'b1;
    for (int a = 0; a < 8; a++) begin
      get("dump addr", 8'(a));
      get("dump value", u_sens.mem[4][a]);
    end
    step(6);
    chk("dump end", 8'h00, {7'h00, tx_valid});
  endtask

  task automatic t_load();
    logic [7:0] q [$];
    // Axes +1000, -1000, +1 then -1, max, min, in milli-g, high byte first
    q = {FAM_LOAD, IDX_ACCEL, 8'h02, 8'h03, 8'he8, 8'hfc, 8'h18, 8'h00, 8'h01,
         8'hff, 8'hff, 8'h7f, 8'hff, 8'h80, 8'h00};
    acc_q.delete();
    acc_ready = 1'b0;
    fork
      frame(q);
      begin
        step(30);
        chk("fifo full valid", 8'h01, {7'h00, acc_valid});
        chk("fifo full stall", 8'h00, {7'h00, rx_ready});
        acc_ready = 1'b1;
      end
    join
    idle();
    step(30);
    chk("load bytes", 8'd12, 8'(acc_q.size()));
    for (int k = 0; k < 12; k++) begin
      chk("load data", q[k + 3], (k < acc_q.size()) ? acc_q[k] : 8'h00);
    end
    chk("fifo empty", 8'h00, {7'h00, acc_valid});
  endtask

  task automatic t_reject();
    int e0, a0, t0, f0;
    e0 = errs;
    a0 = u_sens.n_acc;
    t0 = txs;
    f0 = acc_q.size();
    frame({8'h55});
    frame({FAM_RD, 8'h05, 8'h00});
    frame({FAM_WR, IDX_ACCEL, 8'h08, 8'h99});
    frame({FAM_LOAD, IDX_ACCEL, 8'h00, 8'h11});
    idle();
    step(10);
    chk("reject count", 8'h04, 8'(errs - e0));
    chk("reject access", 8'h00, 8'(u_sens.n_acc - a0));
    chk("reject reply", 8'h00, 8'(txs - t0));
    chk("reject fifo", 8'h00, 8'(acc_q.size() - f0));
    chk("reject mem", 8'(8 * 1 + 32 * 4) ^ 8'h5a, u_sens.mem[4][8]);
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #3_000_000;
    fails++;
    tally_and_finish();
  end

  initial begin
    reset = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    acc_ready = 1'b1;
    slow = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    chk("reset outputs", 8'h00, {3'h0, rx_ready, tx_valid, sens_req, acc_valid, cmd_err});
    reset = 1'b0;
    step(2);
    t_wr_rd();
    t_attr();
    t_dump();
    t_load();
    t_reject();
    tally_and_finish();
  end
endmodule // shub_cmd_tb
`default_nettype wire
